// ==== ssq_pkg.sv ====
/*
 * Shared constants for the serial link start-up sequencer: control characters,
 * decimation codes, word layout, timing counts and the scrambler step.
 * Assumes both link ends run on the same 10 MHz sys_clk.
 */
`default_nettype none
package ssq_pkg;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned CAL_TIME_NS   = 1000;
   localparam int unsigned CAL_CYC       = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CGS_MIN_K     = 4;
   localparam logic [1:0]  SYSREF_HI_CYC = 2'h2;
   localparam logic [2:0]  ILA_MF        = 3'h4;

   localparam logic [7:0] K_CGS   = 8'hBC;
   localparam logic [7:0] K_START = 8'h1C;
   localparam logic [7:0] K_END   = 8'h7C;

   // Decimation codes; bypass sends raw samples
   localparam logic [2:0] DEC_BYPASS = 3'h0;
   localparam logic [2:0] DEC_4      = 3'h1;
   localparam logic [2:0] DEC_8      = 3'h2;
   localparam logic [2:0] DEC_16     = 3'h3;
   localparam logic [2:0] DEC_32     = 3'h4;

   // Word layout
   localparam int unsigned I_LSB      = 17;
   localparam int unsigned Q_LSB      = 2;
   localparam int unsigned RAW_A_LSB  = 20;
   localparam int unsigned RAW_B_LSB  = 8;
   localparam int unsigned CFG_KM1    = 0;
   localparam int unsigned CFG_DEC    = 8;
   localparam int unsigned CFG_SCR    = 11;
   localparam int unsigned CFG_DDR    = 12;
   localparam logic [31:0] WORD_RST   = 32'h0000_0000;
   localparam logic [14:0] SCR_SEED   = 15'h7FFF;

   // One scrambler word step, MSB first, polynomial 1 + x^14 + x^15.
   // Returns {next_state, word}; descr selects the receive direction.
   function automatic logic [46:0] ssq_scr(input logic [31:0] din, input logic [14:0] st_in,
                                           input logic descr);
      logic [31:0] dout;
      logic [14:0] st;
      logic        b;
      st   = st_in;
      dout = 32'h0;
      for (int i = 31; i >= 0; i--) begin
         b       = din[i] ^ st[14] ^ st[13];
         dout[i] = b;
         st      = {st[13:0], descr ? din[i] : b};
      end
      return {st, dout};
   endfunction
endpackage
`default_nettype wire

// ==== ssq_link_if.sv ====
/*
 * Link between the converter end and the receiving capture logic.
 * Assumes both ends share one clock; the bench joins the modports.
 */
`default_nettype none
interface ssq_link_if;
   logic [31:0] tx_word;
   logic        tx_is_k;
   logic        tx_valid;
   logic        sync_n;
   logic        sysref;

   modport dev (output tx_word, output tx_is_k, output tx_valid, input sync_n, input sysref);
   modport rcv (input tx_word, input tx_is_k, input tx_valid, output sync_n, output sysref);
endinterface
`default_nettype wire

// ==== ssq_decim.sv ====
/*
 * Down converter core: takes offset-binary samples straight onto I and, mixed by (-1)^n, onto Q, and
 * averages over 4..32 samples into 15-bit words.
 * Assumes one sample per sys_clk and dec_sel held stable while running.
 */
`default_nettype none
module ssq_decim
   import ssq_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        run,
   input  wire logic [2:0]  dec_sel,
   input  wire logic [11:0] sample,
   output var  logic [14:0] i_out_r,
   output var  logic [14:0] q_out_r,
   output var  logic        valid_r
);
   logic signed [16:0] acc_i_r;
   logic signed [16:0] acc_q_r;
   logic        [4:0]  cnt_r;
   logic        [4:0]  last;
   logic        [2:0]  sh;
   logic signed [16:0] s_ext;
   logic signed [16:0] sum_i;
   logic signed [16:0] sum_q;
   logic signed [19:0] sc_i;
   logic signed [19:0] sc_q;

   always_comb begin
      case (dec_sel)
         DEC_8:   begin last = 5'h07; sh = 3'h3; end
         DEC_16:  begin last = 5'h0F; sh = 3'h4; end
         DEC_32:  begin last = 5'h1F; sh = 3'h5; end
         default: begin last = 5'h03; sh = 3'h2; end
      endcase
      s_ext = 17'(signed'({~sample[11], sample[10:0]}));
      sum_i = acc_i_r + s_ext;
      sum_q = cnt_r[0] ? acc_q_r - s_ext : acc_q_r + s_ext;
      // Average keeps 12 bits; three extra fraction bits below it give the 15-bit word
      sc_i  = ({{3{sum_i[16]}}, sum_i} <<< 3) >>> sh;
      sc_q  = ({{3{sum_q[16]}}, sum_q} <<< 3) >>> sh;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_i_r <= '0;
         acc_q_r <= '0;
         cnt_r   <= 5'h00;
         i_out_r <= 15'h0000;
         q_out_r <= 15'h0000;
         valid_r <= 1'b0;
      end else begin
         valid_r <= 1'b0;
         if (!run) begin
            acc_i_r <= '0;
            acc_q_r <= '0;
            cnt_r   <= 5'h00;
         end else if (cnt_r == last) begin
            i_out_r <= sc_i[14:0];
            q_out_r <= sc_q[14:0];
            valid_r <= 1'b1;
            acc_i_r <= '0;
            acc_q_r <= '0;
            cnt_r   <= 5'h00;
         end else begin
            acc_i_r <= sum_i;
            acc_q_r <= sum_q;
            cnt_r   <= cnt_r + 5'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ==== ssq_dev_end.sv ====
/*
 * Converter end of the link: calibration, link state machine, code group
 * synchronisation, lane alignment sequence and sample output.
 * Assumes configuration inputs are on sys_clk; sync_n and sysref are pins.
 */
`default_nettype none
module ssq_dev_end
   import ssq_pkg::*;
#(
   parameter int unsigned CAL_CYCLES = CAL_CYC
)
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   ssq_link_if.dev          link,
   input  wire logic        link_enable,
   input  wire logic [2:0]  decimation,
   input  wire logic        scrambler_enable,
   input  wire logic [4:0]  frames_per_multiframe_minus_one,
   input  wire logic        ddr_enable,
   input  wire logic        software_calibration_trigger,
   input  wire logic [11:0] adc_sample,
   output var  logic        cal_busy_r,
   output var  logic        link_active_r
);
   typedef enum logic [5:0] {
      ST_OFF  = 6'b000001,
      ST_CAL  = 6'b000010,
      ST_WAIT = 6'b000100,
      ST_CGS  = 6'b001000,
      ST_ILA  = 6'b010000,
      ST_DATA = 6'b100000
   } ssq_dev_st_t;

   ssq_dev_st_t st_r;
   ssq_dev_st_t st_nxt;

   logic [1:0]  sync_sr_r;
   logic [2:0]  sref_sr_r;
   logic        sync_n_s;
   logic        sref_rise;
   logic [2:0]  dec_r;
   logic        scr_r;
   logic [4:0]  km1_r;
   logic        ddr_r;
   logic [15:0] cal_cnt_r;
   logic [4:0]  lmfc_r;
   logic [4:0]  frm_r;
   logic [2:0]  mf_r;
   logic [6:0]  ila_left_r;
   logic [14:0] scr_st_r;
   logic [11:0] raw_hold_r;
   logic        half_r;
   logic [14:0] dd_i;
   logic [14:0] dd_q;
   logic        dd_valid;
   logic [31:0] data_word;
   logic        data_valid;
   logic [46:0] scr_res;
   logic [31:0] ila_word;
   logic        ila_k;

   // Two flops on sync_n, whose second stage feeds logic; three on sysref, whose edge comes from the second and third stages
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_sr_r <= 2'h3;
         sref_sr_r <= 3'h0;
      end else begin
         sync_sr_r <= {sync_sr_r[0], link.sync_n};
         sref_sr_r <= {sref_sr_r[1:0], link.sysref};
      end
   end
   assign sync_n_s  = sync_sr_r[1];
   assign sref_rise = sref_sr_r[1] & ~sref_sr_r[2];

   // Settings are sampled only while the link is off, so writes to a live link have no effect
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dec_r <= DEC_BYPASS;
         scr_r <= 1'b0;
         km1_r <= 5'h00;
         ddr_r <= 1'b0;
      end else if (st_r == ST_OFF) begin
         dec_r <= (decimation > DEC_32) ? DEC_32 : decimation;
         scr_r <= scrambler_enable;
         km1_r <= frames_per_multiframe_minus_one;
         ddr_r <= ddr_enable;
      end
   end

   // Calibration runs for a fixed time; a trigger during it restarts the count
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cal_cnt_r  <= 16'h0000;
         cal_busy_r <= 1'b0;
      end else if (software_calibration_trigger) begin
         cal_cnt_r  <= 16'(CAL_CYCLES - 1);
         cal_busy_r <= 1'b1;
      end else if (cal_cnt_r != 16'h0000) begin
         cal_cnt_r <= cal_cnt_r - 16'h0001;
      end else begin
         cal_busy_r <= 1'b0;
      end
   end

   // Multiframe clock; one frame per sys_clk
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lmfc_r <= 5'h00;
      end else if (sref_rise) begin
         lmfc_r <= 5'h00;
      end else if (lmfc_r >= km1_r) begin
         lmfc_r <= 5'h00;
      end else begin
         lmfc_r <= lmfc_r + 5'h01;
      end
   end

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_OFF:  if (link_enable) st_nxt = ST_CAL;
         ST_CAL:  if (!cal_busy_r) st_nxt = ST_WAIT;
         ST_WAIT: if (!sync_n_s) st_nxt = ST_CGS;
         ST_CGS:  if (sync_n_s && lmfc_r == 5'h00) st_nxt = ST_ILA;
         ST_ILA:  if (mf_r == ILA_MF - 3'h1 && frm_r == km1_r) st_nxt = ST_DATA;
         ST_DATA: if (!sync_n_s) st_nxt = ST_CGS;
         default: st_nxt = ST_OFF;
      endcase
      if (!link_enable) begin
         st_nxt = ST_OFF;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= ST_OFF;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Alignment frame and multiframe position
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         frm_r      <= 5'h00;
         mf_r       <= 3'h0;
         ila_left_r <= 7'h00;
      end else if (st_r != ST_ILA) begin
         frm_r      <= 5'h00;
         mf_r       <= 3'h0;
         ila_left_r <= 7'(ILA_MF) * ({2'h0, km1_r} + 7'h01) - 7'h01;
      end else if (frm_r == km1_r) begin
         frm_r      <= 5'h00;
         mf_r       <= mf_r + 3'h1;
         ila_left_r <= ila_left_r - 7'h01;
      end else begin
         frm_r      <= frm_r + 5'h01;
         ila_left_r <= ila_left_r - 7'h01;
      end
   end

   // Decimator starts late in alignment so a word is ready on the first data frame; needs 4*(km1+1) >= factor
   ssq_decim ssq_decim_inst (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .run     (dec_r != DEC_BYPASS && (st_r == ST_DATA || (st_r == ST_ILA && ila_left_r < (7'h04 << (dec_r - 3'h1))))),
      .dec_sel (dec_r),
      .sample  (adc_sample),
      .i_out_r (dd_i),
      .q_out_r (dd_q),
      .valid_r (dd_valid)
   );

   // Bypass pairing alternates words in double rate
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         raw_hold_r <= 12'h000;
         half_r     <= 1'b0;
      end else begin
         raw_hold_r <= adc_sample;
         half_r     <= (st_r == ST_DATA) ? ~half_r : 1'b0;
      end
   end

   always_comb begin
      data_word  = WORD_RST;
      data_valid = 1'b0;
      if (dec_r == DEC_BYPASS) begin
         data_word[RAW_A_LSB +: 12] = ddr_r ? raw_hold_r : adc_sample;
         if (ddr_r) begin
            data_word[RAW_B_LSB +: 12] = adc_sample;
         end
         data_valid = ddr_r ? ~half_r : 1'b1;
      end else begin
         data_word[I_LSB +: 15] = dd_i;
         data_word[Q_LSB +: 15] = dd_q;
         data_valid             = dd_valid;
      end
      scr_res = ssq_scr(data_word, scr_st_r, 1'b0);
   end

   // Alignment content: start mark, settings in second multiframe, end mark
   always_comb begin
      ila_word = {27'h0, frm_r};
      ila_k    = 1'b0;
      if (frm_r == 5'h00) begin
         ila_word = {24'h0, K_START};
         ila_k    = 1'b1;
      end else if (frm_r == km1_r) begin
         ila_word = {24'h0, K_END};
         ila_k    = 1'b1;
      end else if (mf_r == 3'h1 && frm_r == 5'h01) begin
         ila_word                = WORD_RST;
         ila_word[CFG_KM1 +: 5]  = km1_r;
         ila_word[CFG_DEC +: 3]  = dec_r;
         ila_word[CFG_SCR]       = scr_r;
         ila_word[CFG_DDR]       = ddr_r;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         link.tx_word  <= WORD_RST;
         link.tx_is_k  <= 1'b0;
         link.tx_valid <= 1'b0;
         link_active_r <= 1'b0;
         scr_st_r      <= SCR_SEED;
      end else begin
         link.tx_word  <= WORD_RST;
         link.tx_is_k  <= 1'b0;
         link.tx_valid <= 1'b0;
         link_active_r <= (st_r == ST_DATA);
         case (st_r)
            ST_CGS: begin
               link.tx_word <= {24'h0, K_CGS};
               link.tx_is_k <= 1'b1;
               scr_st_r     <= SCR_SEED;
            end
            ST_ILA: begin
               link.tx_word <= ila_word;
               link.tx_is_k <= ila_k;
            end
            ST_DATA: begin
               // Data starts the cycle after the last end mark
               if (data_valid) begin
                  link.tx_word  <= scr_r ? scr_res[31:0] : data_word;
                  link.tx_valid <= 1'b1;
                  if (scr_r) begin
                     scr_st_r <= scr_res[46:32];
                  end
               end
            end
            default: begin
               scr_st_r <= SCR_SEED;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== ssq_rcv_end.sv ====
/*
 * Capture-side end of the link: requests synchronisation, releases it after
 * steady code group characters, follows the alignment sequence, then
 * delivers sample words; also issues SYSREF pulses on request.
 * Assumes the converter end shares sys_clk.
 */
`default_nettype none
module ssq_rcv_end
   import ssq_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   ssq_link_if.rcv          link,
   input  wire logic        rx_enable,
   input  wire logic        sysref_request,
   output var  logic [31:0] rx_word_r,
   output var  logic        rx_valid_r,
   output var  logic        rx_up_r,
   output var  logic [12:0] rx_cfg_r
);
   typedef enum logic [3:0] {
      RS_IDLE = 4'b0001,
      RS_CGS  = 4'b0010,
      RS_ILA  = 4'b0100,
      RS_DATA = 4'b1000
   } ssq_rcv_st_t;

   ssq_rcv_st_t st_r;
   logic [2:0]  kcnt_r;
   logic [2:0]  acnt_r;
   logic        cfg_seen_r;
   logic [1:0]  sref_cnt_r;
   logic [14:0] dscr_st_r;
   logic [46:0] dscr;
   logic        is_cgs;
   logic        is_end;

   assign is_cgs = link.tx_is_k && link.tx_word[7:0] == K_CGS;
   assign is_end = link.tx_is_k && link.tx_word[7:0] == K_END;
   assign dscr   = ssq_scr(link.tx_word, dscr_st_r, 1'b1);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         link.sysref <= 1'b0;
         sref_cnt_r  <= 2'h0;
      end else if (sysref_request && sref_cnt_r == 2'h0) begin
         link.sysref <= 1'b1;
         sref_cnt_r  <= SYSREF_HI_CYC;
      end else if (sref_cnt_r != 2'h0) begin
         sref_cnt_r  <= sref_cnt_r - 2'h1;
         link.sysref <= (sref_cnt_r != 2'h1);
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r        <= RS_IDLE;
         link.sync_n <= 1'b1;
         kcnt_r      <= 3'h0;
         acnt_r      <= 3'h0;
         cfg_seen_r  <= 1'b0;
         rx_cfg_r    <= 13'h0000;
         rx_word_r   <= WORD_RST;
         rx_valid_r  <= 1'b0;
         rx_up_r     <= 1'b0;
         dscr_st_r   <= SCR_SEED;
      end else begin
         rx_valid_r <= 1'b0;
         case (st_r)
            RS_IDLE: begin
               link.sync_n <= 1'b1;
               rx_up_r     <= 1'b0;
               if (rx_enable) begin
                  st_r        <= RS_CGS;
                  link.sync_n <= 1'b0;
                  kcnt_r      <= 3'h0;
               end
            end
            RS_CGS: begin
               kcnt_r <= is_cgs ? ((kcnt_r == 3'(CGS_MIN_K)) ? kcnt_r : kcnt_r + 3'h1) : 3'h0;
               if (kcnt_r == 3'(CGS_MIN_K)) begin
                  link.sync_n <= 1'b1;
                  st_r        <= RS_ILA;
                  acnt_r      <= 3'h0;
                  cfg_seen_r  <= 1'b0;
               end
            end
            RS_ILA: begin
               if (!link.tx_is_k && acnt_r == 3'h1 && !cfg_seen_r) begin
                  rx_cfg_r   <= link.tx_word[12:0];
                  cfg_seen_r <= 1'b1;
               end
               if (is_end) begin
                  acnt_r <= acnt_r + 3'h1;
                  if (acnt_r == ILA_MF - 3'h1) begin
                     st_r      <= RS_DATA;
                     rx_up_r   <= 1'b1;
                     dscr_st_r <= SCR_SEED;
                  end
               end
            end
            RS_DATA: begin
               if (link.tx_valid) begin
                  rx_word_r  <= rx_cfg_r[CFG_SCR] ? dscr[31:0] : link.tx_word;
                  rx_valid_r <= 1'b1;
                  if (rx_cfg_r[CFG_SCR]) begin
                     dscr_st_r <= dscr[46:32];
                  end
               end
            end
            default: st_r <= RS_IDLE;
         endcase
         if (!rx_enable) begin
            st_r        <= RS_IDLE;
            link.sync_n <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== ssq_asserts.sv ====
/*
 * Link-level checks for the start-up sequencer, on the wires between both ends.
 * Assumes one shared sys_clk and is instantiated beside the link interface.
 */
`default_nettype none
module ssq_asserts
   import ssq_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic [31:0] tx_word,
   input wire logic        tx_is_k,
   input wire logic        tx_valid,
   input wire logic        sync_n,
   input wire logic        sysref
);
   logic       cgs_seen_r;
   logic [3:0] bc_run_r;
   wire logic  is_cgs   = tx_is_k && (tx_word[7:0] == K_CGS);
   wire logic  is_start = tx_is_k && (tx_word[7:0] == K_START);
   wire logic  is_end   = tx_is_k && (tx_word[7:0] == K_END);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cgs_seen_r <= 1'b0;
      end else begin
         cgs_seen_r <= is_cgs;
      end
   end

   // Saturates so a long wait never wraps to a short run
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bc_run_r <= 4'h0;
      end else begin
         bc_run_r <= !is_cgs ? 4'h0 : ((bc_run_r == 4'hF) ? bc_run_r : bc_run_r + 4'h1);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   property p_cgs_answer;
      $fell(sync_n) |-> ##[3:4] is_cgs;
   endproperty
   a_cgs_answer: assert property (p_cgs_answer) else $error("no sync character after request");

   property p_cgs_hold;
      !sync_n [*8] |-> is_cgs;
   endproperty
   a_cgs_hold: assert property (p_cgs_hold) else $error("sync characters stopped early");

   property p_sync_release;
      $rose(sync_n) && cgs_seen_r |-> bc_run_r >= 4'h4;
   endproperty
   a_sync_release: assert property (p_sync_release) else $error("sync released too soon");

   property p_ila_start;
      $rose(sync_n) && cgs_seen_r |-> ##[1:40] is_start;
   endproperty
   a_ila_start: assert property (p_ila_start) else $error("alignment did not start");

   property p_no_gap;
      is_end |=> (tx_valid || is_start);
   endproperty
   a_no_gap: assert property (p_no_gap) else $error("gap after alignment frame");

   property p_frame_one;
      is_start |=> !tx_is_k;
   endproperty
   a_frame_one: assert property (p_frame_one) else $error("control char in frame one");

   property p_data_plain;
      tx_valid |-> !tx_is_k;
   endproperty
   a_data_plain: assert property (p_data_plain) else $error("data word flagged as control");

   property p_sysref_width;
      $rose(sysref) |-> sysref [*2] ##1 !sysref;
   endproperty
   a_sysref_width: assert property (p_sysref_width) else $error("sysref pulse width wrong");
endmodule
`default_nettype wire

// ==== serial_link_startup_sequencer_tb_top.sv ====
/*
 * Self-checking bench: both link ends joined by the interface, checker beside it.
 * Assumes a short calibration (CAL_CYCLES = 2) and inputs driven at falling edges.
 */
`default_nettype none
module serial_link_startup_sequencer_tb_top
   import ssq_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

   logic        sys_clk, sys_rst, link_enable, scrambler_enable, ddr_enable;
   logic        software_calibration_trigger, rx_enable, sysref_request;
   logic [2:0]  decimation;
   logic [4:0]  frames_per_multiframe_minus_one;
   logic [11:0] adc_sample;
   logic        cal_busy_r, link_active_r, rx_valid_r, rx_up_r;
   logic [31:0] rx_word_r;
   logic [12:0] rx_cfg_r;
   int          bad_count, num_checks, cycle_cnt;

   ssq_link_if lk ();

   ssq_dev_end #(.CAL_CYCLES(2)) ssq_dev_end_inst (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .link(lk.dev), .link_enable(link_enable),
      .decimation(decimation), .scrambler_enable(scrambler_enable),
      .frames_per_multiframe_minus_one(frames_per_multiframe_minus_one), .ddr_enable(ddr_enable),
      .software_calibration_trigger(software_calibration_trigger), .adc_sample(adc_sample),
      .cal_busy_r(cal_busy_r), .link_active_r(link_active_r));

   ssq_rcv_end ssq_rcv_end_inst (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .link(lk.rcv), .rx_enable(rx_enable),
      .sysref_request(sysref_request), .rx_word_r(rx_word_r), .rx_valid_r(rx_valid_r),
      .rx_up_r(rx_up_r), .rx_cfg_r(rx_cfg_r));

   ssq_asserts ssq_asserts_inst (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .tx_word(lk.tx_word), .tx_is_k(lk.tx_is_k),
      .tx_valid(lk.tx_valid), .sync_n(lk.sync_n), .sysref(lk.sysref));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Whole run needs about 600 cycles
   always @(posedge sys_clk) begin
      cycle_cnt <= cycle_cnt + 1;
      if (cycle_cnt == 5000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic bring_up(input logic [2:0] dec, input logic scr, input logic ddr, input logic [4:0] km1);
      @(negedge sys_clk);
      link_enable = 1'b0;
      rx_enable = 1'b0;
      repeat (4) @(negedge sys_clk);
      check_val({31'h0, link_active_r}, 32'h0);
      decimation = dec;
      scrambler_enable = scr;
      ddr_enable = ddr;
      frames_per_multiframe_minus_one = km1;
      @(negedge sys_clk);
      software_calibration_trigger = 1'b1;
      @(negedge sys_clk);
      software_calibration_trigger = 1'b0;
      @(negedge sys_clk);
      check_val({31'h0, cal_busy_r}, 32'h1);
      for (int i = 0; i < 20 && cal_busy_r; i++) @(negedge sys_clk);
      check_val({31'h0, cal_busy_r}, 32'h0);
      link_enable = 1'b1;
      repeat (3) @(negedge sys_clk);
      sysref_request = 1'b1;
      @(negedge sys_clk);
      sysref_request = 1'b0;
      repeat (4) @(negedge sys_clk);
      rx_enable = 1'b1;
      for (int i = 0; i < 400 && !rx_up_r; i++) @(negedge sys_clk);
      check_val({31'h0, rx_up_r}, 32'h1);
      check_val({31'h0, link_active_r}, 32'h1);
      check_val({19'h0, rx_cfg_r}, {19'h0, ddr, scr, dec, 3'h0, km1});
   endtask

   // Spacing of received words shows the decimation really in force
   task automatic check_gap(input int exp);
      int g;
      for (int i = 0; i < 100 && !rx_valid_r; i++) @(negedge sys_clk);
      @(negedge sys_clk);
      for (g = 1; g < 100 && !rx_valid_r; g++) @(negedge sys_clk);
      check_val(g, exp);
   endtask

   task automatic complex_run(input logic [2:0] dec, input int d);
      adc_sample = 12'h900;
      bring_up(dec, dec[0], 1'b0, 5'h7 + {2'h0, dec});
      check_gap(d);
      check_val(rx_word_r, 32'h10000000);
   endtask

   task automatic bypass_run(input logic ddr);
      adc_sample = 12'hA5C;
      bring_up(DEC_BYPASS, 1'b1, ddr, 5'h7);
      check_gap(ddr ? 2 : 1);
      check_val({20'h0, rx_word_r[31:20]}, 32'h00000A5C);
      if (ddr) begin
         check_val({20'h0, rx_word_r[19:8]}, 32'h00000A5C);
      end
   endtask

   task automatic locked_options();
      int hits;
      hits = 0;
      bring_up(DEC_8, 1'b0, 1'b0, 5'h3);
      decimation = DEC_4;
      repeat (3) @(negedge sys_clk);
      check_gap(8);
      link_enable = 1'b0;
      repeat (3) @(negedge sys_clk);
      for (int i = 0; i < 20; i++) begin
         @(negedge sys_clk);
         if (lk.tx_valid !== 1'b0 || rx_valid_r !== 1'b0) begin
            hits++;
         end
      end
      check_val(hits, 0);
      check_val(lk.tx_word, 32'h0);
      check_val({31'h0, link_active_r}, 32'h0);
   endtask

   initial begin
      sys_rst = 1'b1;
      link_enable = 1'b0;
      scrambler_enable = 1'b0;
      ddr_enable = 1'b0;
      software_calibration_trigger = 1'b0;
      rx_enable = 1'b0;
      sysref_request = 1'b0;
      decimation = DEC_4;
      frames_per_multiframe_minus_one = 5'h3;
      adc_sample = 12'h800;
      bad_count = 0;
      num_checks = 0;
      cycle_cnt = 0;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      sys_rst = 1'b0;
      @(negedge sys_clk);
      check_val({28'h0, lk.tx_valid, lk.tx_is_k, lk.sync_n, lk.sysref}, 32'h2);
      for (int k = 0; k < 4; k++) begin
         complex_run(3'(k + 1), 4 << k);
      end
      bypass_run(1'b0);
      bypass_run(1'b1);
      locked_options();
      tally_and_finish();
   end
endmodule
`default_nettype wire
